// >>> design/fcp_defs.vh
// Register map, field positions and reset values of the flash config/protection block
`ifndef FCP_DEFS_VH
`define FCP_DEFS_VH

`define FCP_ADDR_W 4
`define FCP_DATA_W 8

`define FCP_OFS_CONFIG 4'h3
`define FCP_OFS_PROTECTION 4'h4

`define FCP_CFG_BUF_EMPTY_IE 7
`define FCP_CFG_CMD_DONE_IE 6
`define FCP_CFG_KEY_ACCESS 5
`define FCP_CFG_RESET 8'h00
`define FCP_CFG_RW_MASK 8'he0

`define FCP_PROT_OPEN 7
`define FCP_PROT_RSVD 6
`define FCP_PROT_HIGH_DIS 5
`define FCP_PROT_HIGH_SIZE_HI 4
`define FCP_PROT_HIGH_SIZE_LO 3
`define FCP_PROT_LOW_DIS 2
`define FCP_PROT_LOW_SIZE_HI 1
`define FCP_PROT_LOW_SIZE_LO 0
`define FCP_PROT_RESET 8'hbf

`define FCP_SCN_W 3

`endif

// >>> design/fcp_rst_sync.v
// Reset release synchroniser: asynchronous assert, two-flop release
`timescale 1ns/1ps
`default_nettype none

module fcp_rst_sync (
  input wire clk_in,
  input wire rst_n_in,
  output wire rst_n_out
);

  reg stage1_reg;
  reg stage2_reg;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= 1'b1;
      stage2_reg <= stage1_reg;
    end
  end

  assign rst_n_out = stage2_reg;

endmodule // fcp_rst_sync

`default_nettype wire

// >>> design/fcp_prot_check.v
// Protection write filter: builds candidate value and checks scenario move
`timescale 1ns/1ps
`default_nettype none
`include "fcp_defs.vh"

module fcp_prot_check (
  input wire [7:0] cur_in,
  input wire [7:0] wdata_in,
  output wire [7:0] next_out,
  output wire allowed_out,
  output wire [2:0] cur_scn_out
);

  // Scenario number from open, high-disable and low-disable bits
  function [2:0] scn_of;
    input [7:0] v;
    begin
      case ({v[`FCP_PROT_OPEN], v[`FCP_PROT_HIGH_DIS], v[`FCP_PROT_LOW_DIS]})
        3'b100: scn_of = 3'h0;
        3'b101: scn_of = 3'h1;
        3'b110: scn_of = 3'h2;
        3'b000: scn_of = 3'h3;
        3'b001: scn_of = 3'h4;
        3'b010: scn_of = 3'h5;
        3'b011: scn_of = 3'h6;
        default: scn_of = 3'h7;
      endcase
    end
  endfunction

  function move_ok;
    input [2:0] from;
    input [2:0] to;
    begin
      case (from)
        3'h0: move_ok = (to <= 3'h3);
        3'h1: move_ok = (to == 3'h1) || (to == 3'h3);
        3'h2: move_ok = (to == 3'h2) || (to == 3'h3);
        3'h3: move_ok = (to == 3'h3);
        3'h4: move_ok = (to == 3'h3) || (to == 3'h4);
        3'h5: move_ok = (to >= 3'h2) && (to <= 3'h5);
        default: move_ok = 1'b1;
      endcase
    end
  endfunction

  wire open_bit;
  wire [1:0] high_size;
  wire [1:0] low_size;

  assign open_bit = cur_in[`FCP_PROT_OPEN] & wdata_in[`FCP_PROT_OPEN];
  assign high_size = cur_in[`FCP_PROT_HIGH_DIS] ?
    wdata_in[`FCP_PROT_HIGH_SIZE_HI:`FCP_PROT_HIGH_SIZE_LO] :
    cur_in[`FCP_PROT_HIGH_SIZE_HI:`FCP_PROT_HIGH_SIZE_LO];
  assign low_size = cur_in[`FCP_PROT_LOW_DIS] ?
    wdata_in[`FCP_PROT_LOW_SIZE_HI:`FCP_PROT_LOW_SIZE_LO] :
    cur_in[`FCP_PROT_LOW_SIZE_HI:`FCP_PROT_LOW_SIZE_LO];

  assign next_out = {open_bit, 1'b0, wdata_in[`FCP_PROT_HIGH_DIS], high_size,
    wdata_in[`FCP_PROT_LOW_DIS], low_size};
  assign allowed_out = move_ok(scn_of(cur_in), scn_of(next_out));
  assign cur_scn_out = scn_of(cur_in);

endmodule // fcp_prot_check

`default_nettype wire

// >>> design/fcp_ctrl.v
// Flash configuration and protection register control
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fcp_defs.vh"

module fcp_ctrl #(
  parameter [7:0] PROT_RESET = `FCP_PROT_RESET
) (
  input wire SYS_CLK_IN,
  input wire RESET_N_IN,
  input wire CE_IN,
  input wire [`FCP_ADDR_W-1:0] ADDR_IN,
  input wire [`FCP_DATA_W-1:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  output wire [`FCP_DATA_W-1:0] RDATA_OUT,
  input wire CMD_BUF_EMPTY_FLAG_IN,
  input wire CMD_COMPLETE_FLAG_IN,
  input wire BACKDOOR_KEY_ENABLE_IN,
  input wire ARRAY_WR_IN,
  input wire ARRAY_RD_IN,
  output wire CMD_BUF_EMPTY_IRQ_OUT,
  output wire CMD_COMPLETE_IRQ_OUT,
  output wire CMD_SEQ_START_OUT,
  output wire KEY_WORD_WR_OUT,
  output wire ARRAY_RD_INVALID_OUT,
  output wire [2:0] PROT_SCENARIO_OUT,
  output wire [7:0] PROT_VALUE_OUT,
  output wire PROT_WR_REFUSED_OUT
);

  wire rst_n;
  wire [7:0] prot_cand;
  wire prot_ok;
  wire [2:0] prot_scn;

  reg [7:0] cfg_reg;
  reg [7:0] cfg_next;
  reg [7:0] prot_reg;
  reg [7:0] prot_next;
  reg [7:0] rdata_reg;
  reg [7:0] rdata_next;
  reg buf_irq_reg;
  reg done_irq_reg;
  reg seq_start_reg;
  reg key_wr_reg;
  reg rd_invalid_reg;
  reg [2:0] scn_reg;
  reg refused_reg;
  reg refused_next;

  // Register decode shared by read and write paths
  function sel_cfg;
    input [`FCP_ADDR_W-1:0] a;
    begin
      sel_cfg = (a == `FCP_OFS_CONFIG);
    end
  endfunction

  function sel_prot;
    input [`FCP_ADDR_W-1:0] a;
    begin
      sel_prot = (a == `FCP_OFS_PROTECTION);
    end
  endfunction

  fcp_rst_sync u_rst_sync (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .rst_n_out(rst_n)
  );

  fcp_prot_check u_prot_check (
    .cur_in(prot_reg),
    .wdata_in(WDATA_IN),
    .next_out(prot_cand),
    .allowed_out(prot_ok),
    .cur_scn_out(prot_scn)
  );

  // Configuration write: interrupt enables always, key access gated
  always @* begin
    cfg_next = cfg_reg;
    if (WR_IN && sel_cfg(ADDR_IN)) begin
      cfg_next[`FCP_CFG_BUF_EMPTY_IE] = WDATA_IN[`FCP_CFG_BUF_EMPTY_IE];
      cfg_next[`FCP_CFG_CMD_DONE_IE] = WDATA_IN[`FCP_CFG_CMD_DONE_IE];
      if (BACKDOOR_KEY_ENABLE_IN) begin
        cfg_next[`FCP_CFG_KEY_ACCESS] = WDATA_IN[`FCP_CFG_KEY_ACCESS];
      end
    end
    cfg_next = cfg_next & `FCP_CFG_RW_MASK;
  end

  // Protection write: whole write dropped on a refused move
  always @* begin
    prot_next = prot_reg;
    refused_next = 1'b0;
    if (WR_IN && sel_prot(ADDR_IN)) begin
      if (prot_ok) begin
        prot_next = prot_cand;
      end else begin
        refused_next = 1'b1;
      end
    end
  end

  // Read data valid only in the cycle after the read strobe
  always @* begin
    rdata_next = 8'h00;
    if (RD_IN) begin
      if (sel_cfg(ADDR_IN)) begin
        rdata_next = cfg_reg & `FCP_CFG_RW_MASK;
      end else if (sel_prot(ADDR_IN)) begin
        rdata_next = prot_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= `FCP_CFG_RESET;
      prot_reg <= PROT_RESET;
      rdata_reg <= 8'h00;
      buf_irq_reg <= 1'b0;
      done_irq_reg <= 1'b0;
      seq_start_reg <= 1'b0;
      key_wr_reg <= 1'b0;
      rd_invalid_reg <= 1'b0;
      scn_reg <= 3'h7;
      refused_reg <= 1'b0;
    end else if (CE_IN) begin
      cfg_reg <= cfg_next;
      prot_reg <= prot_next;
      rdata_reg <= rdata_next;
      buf_irq_reg <= cfg_reg[`FCP_CFG_BUF_EMPTY_IE] & CMD_BUF_EMPTY_FLAG_IN;
      done_irq_reg <= cfg_reg[`FCP_CFG_CMD_DONE_IE] & CMD_COMPLETE_FLAG_IN;
      seq_start_reg <= ARRAY_WR_IN & ~cfg_reg[`FCP_CFG_KEY_ACCESS];
      key_wr_reg <= ARRAY_WR_IN & cfg_reg[`FCP_CFG_KEY_ACCESS];
      rd_invalid_reg <= ARRAY_RD_IN & cfg_reg[`FCP_CFG_KEY_ACCESS];
      scn_reg <= prot_scn;
      refused_reg <= refused_next;
    end
  end

  assign RDATA_OUT = rdata_reg;
  assign CMD_BUF_EMPTY_IRQ_OUT = buf_irq_reg;
  assign CMD_COMPLETE_IRQ_OUT = done_irq_reg;
  assign CMD_SEQ_START_OUT = seq_start_reg;
  assign KEY_WORD_WR_OUT = key_wr_reg;
  assign ARRAY_RD_INVALID_OUT = rd_invalid_reg;
  assign PROT_SCENARIO_OUT = scn_reg;
  assign PROT_VALUE_OUT = prot_reg;
  assign PROT_WR_REFUSED_OUT = refused_reg;

endmodule // fcp_ctrl

`default_nettype wire

// >>> test/fcp_ctrl_properties.sv
// Port-level checks of the flash config/protection block
`timescale 1ns/1ps
`default_nettype none
module fcp_ctrl_properties (
  input wire SYS_CLK_IN,
  input wire RESET_N_IN,
  input wire [3:0] ADDR_IN,
  input wire WR_IN,
  input wire RD_IN,
  input wire [7:0] RDATA_OUT,
  input wire CMD_BUF_EMPTY_FLAG_IN,
  input wire CMD_COMPLETE_FLAG_IN,
  input wire ARRAY_WR_IN,
  input wire ARRAY_RD_IN,
  input wire CMD_BUF_EMPTY_IRQ_OUT,
  input wire CMD_COMPLETE_IRQ_OUT,
  input wire CMD_SEQ_START_OUT,
  input wire KEY_WORD_WR_OUT,
  input wire ARRAY_RD_INVALID_OUT,
  input wire [7:0] PROT_VALUE_OUT,
  input wire PROT_WR_REFUSED_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  property p_be; !CMD_BUF_EMPTY_FLAG_IN |=> !CMD_BUF_EMPTY_IRQ_OUT; endproperty
  a_be: assert property (p_be) else $error("buffer irq without flag");
  property p_cc; !CMD_COMPLETE_FLAG_IN |=> !CMD_COMPLETE_IRQ_OUT; endproperty
  a_cc: assert property (p_cc) else $error("complete irq without flag");
  property p_sq;
    CMD_SEQ_START_OUT || KEY_WORD_WR_OUT |->
      $past(ARRAY_WR_IN) && !(CMD_SEQ_START_OUT && KEY_WORD_WR_OUT);
  endproperty
  a_sq: assert property (p_sq) else $error("array write decode wrong");
  property p_iv; ARRAY_RD_INVALID_OUT |-> $past(ARRAY_RD_IN); endproperty
  a_iv: assert property (p_iv) else $error("invalid read without read");
  property p_op; !PROT_VALUE_OUT[7] |=> !PROT_VALUE_OUT[7]; endproperty
  a_op: assert property (p_op) else $error("open bit came back");
  property p_rf;
    PROT_WR_REFUSED_OUT |-> $past(WR_IN && ADDR_IN == 4'h4) && $stable(PROT_VALUE_OUT);
  endproperty
  a_rf: assert property (p_rf) else $error("refusal wrong");
  property p_rp; $past(RD_IN && ADDR_IN == 4'h4) |-> RDATA_OUT == $past(PROT_VALUE_OUT); endproperty
  a_rp: assert property (p_rp) else $error("protection readback wrong");
  property p_cf; $past(RD_IN && ADDR_IN == 4'h3) |-> RDATA_OUT[4:0] == 5'h00; endproperty
  a_cf: assert property (p_cf) else $error("config low bits not zero");
endmodule // fcp_ctrl_properties
bind fcp_ctrl fcp_ctrl_properties u_chk (.SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN),
  .ADDR_IN(ADDR_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .CMD_BUF_EMPTY_FLAG_IN(CMD_BUF_EMPTY_FLAG_IN), .CMD_COMPLETE_FLAG_IN(CMD_COMPLETE_FLAG_IN),
  .ARRAY_WR_IN(ARRAY_WR_IN), .ARRAY_RD_IN(ARRAY_RD_IN),
  .CMD_BUF_EMPTY_IRQ_OUT(CMD_BUF_EMPTY_IRQ_OUT), .CMD_COMPLETE_IRQ_OUT(CMD_COMPLETE_IRQ_OUT),
  .CMD_SEQ_START_OUT(CMD_SEQ_START_OUT), .KEY_WORD_WR_OUT(KEY_WORD_WR_OUT),
  .ARRAY_RD_INVALID_OUT(ARRAY_RD_INVALID_OUT), .PROT_VALUE_OUT(PROT_VALUE_OUT),
  .PROT_WR_REFUSED_OUT(PROT_WR_REFUSED_OUT));
`default_nettype wire

// >>> test/flash_config_protection_ctrl_tb.sv
// Self-checking bench of the flash config/protection block
`timescale 1ns/1ps
`default_nettype none
module flash_config_protection_ctrl_tb;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, be = 0, cc = 0, key = 0, awr = 0, ard = 0;
  logic ce = 1;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0, d, w, cur, cand, exp_v;
  logic rf, r_exp;
  wire [7:0] rdata, prot;
  wire be_irq, cc_irq, seq, kwr, inv, refused;
  wire [2:0] scn_o;
  integer errors = 0, compares = 0, cyc = 0, i, j;
  fcp_ctrl dut (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CMD_BUF_EMPTY_FLAG_IN(be),
    .CMD_COMPLETE_FLAG_IN(cc), .BACKDOOR_KEY_ENABLE_IN(key), .ARRAY_WR_IN(awr),
    .ARRAY_RD_IN(ard), .CMD_BUF_EMPTY_IRQ_OUT(be_irq), .CMD_COMPLETE_IRQ_OUT(cc_irq),
    .CMD_SEQ_START_OUT(seq), .KEY_WORD_WR_OUT(kwr), .ARRAY_RD_INVALID_OUT(inv),
    .PROT_SCENARIO_OUT(scn_o), .PROT_VALUE_OUT(prot), .PROT_WR_REFUSED_OUT(refused));
  initial forever #2.5 clk = ~clk;
  function logic [2:0] scn(input [7:0] v);
    case ({v[7], v[5], v[2]})
      3'b100: scn = 3'd0;
      3'b101: scn = 3'd1;
      3'b110: scn = 3'd2;
      3'b000: scn = 3'd3;
      3'b001: scn = 3'd4;
      3'b010: scn = 3'd5;
      3'b011: scn = 3'd6;
      default: scn = 3'd7;
    endcase
  endfunction
  function logic ok(input [2:0] f, input [2:0] t);
    case (f)
      3'd0: ok = t <= 3'd3;
      3'd1: ok = t == 3'd1 || t == 3'd3;
      3'd2: ok = t == 3'd2 || t == 3'd3;
      3'd3: ok = t == 3'd3;
      3'd4: ok = t == 3'd3 || t == 3'd4;
      3'd5: ok = t >= 3'd2 && t <= 3'd5;
      default: ok = 1'b1;
    endcase
  endfunction
  task chk(input [7:0] s, input [7:0] e);
    compares = compares + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task end_sim;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task acc(input logic we, input [3:0] a, input [7:0] v);
    @(posedge clk);
    wr <= we;
    rd <= !we;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1 d = rdata;
    rf = refused;
  endtask
  task arr(input logic aw, input logic ar);
    @(posedge clk);
    awr <= aw;
    ard <= ar;
    @(posedge clk);
    awr <= 0;
    ard <= 0;
    #1;
  endtask
  task rst;
    @(posedge clk) rst_n <= 0;
    repeat (20) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      end_sim;
    end
  end
  initial begin
    void'($urandom(32'h9b9b));
    rst;
    acc(0, 4'h3, 0); chk(d, 8'h00);
    acc(0, 4'h4, 0); chk(d, 8'hbf);
    chk({5'h0, scn_o}, 8'h07);
    acc(0, 4'h9, 0); chk(d, 8'h00);
    acc(1, 4'h3, 8'hff); acc(0, 4'h3, 0); chk(d, 8'hc0);
    @(posedge clk) key <= 1;
    acc(1, 4'h3, 8'hff); acc(0, 4'h3, 0); chk(d, 8'he0);
    @(posedge clk) ce <= 0;
    acc(1, 4'h3, 8'h00);
    @(posedge clk) ce <= 1;
    acc(0, 4'h3, 0); chk(d, 8'he0);
    $display("test config done");
    for (i = 0; i < 2; i++) begin
      acc(1, 4'h3, i ? 8'h00 : 8'he0);
      arr(1, 0); chk({5'h0, kwr, seq, inv}, i ? 8'h02 : 8'h04);
      arr(0, 1); chk({5'h0, kwr, seq, inv}, i ? 8'h00 : 8'h01);
      for (j = 0; j < 6; j++) begin
        @(posedge clk) {be, cc} <= 2'($urandom);
        @(posedge clk) #1 chk({6'h0, be_irq, cc_irq}, i ? 8'h00 : {6'h0, be, cc});
      end
    end
    $display("test flash side done");
    for (i = 0; i < 56; i++) begin
      if (i % 8 == 0) rst;
      if (i % 8 == 0) cur = 8'hbf;
      w = (i % 8 == 3) ? 8'hff : 8'($urandom);
      cand = {cur[7] & w[7], 1'b0, w[5], cur[5] ? w[4:3] : cur[4:3], w[2], cur[2] ? w[1:0] : cur[1:0]};
      r_exp = !ok(scn(cur), scn(cand));
      exp_v = r_exp ? cur : cand;
      acc(1, 4'h4, w); chk({7'h0, rf}, {7'h0, r_exp});
      acc(0, 4'h4, 0); chk(d, exp_v);
      chk(prot, exp_v);
      chk({5'h0, scn_o}, {5'h0, scn(exp_v)});
      cur = exp_v;
    end
    $display("test protection done");
    end_sim;
  end
endmodule // flash_config_protection_ctrl_tb
`default_nettype wire
